// file: shared/frpic_pkg.sv
// constants shared by the serial flash resume, power-down and id block
package frpic_pkg;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_SLEEP   = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_MFR_ID1 = 8'h90;
  localparam logic [7:0] OP_MFR_ID2 = 8'h92;
  localparam logic [7:0] OP_MFR_ID4 = 8'h94;

  // ****************************************************************
  // frame layout in link clocks after the opcode
  // ****************************************************************
  localparam logic [4:0] OPC_LAST     = 5'h07;  // eighth opcode bit
  localparam logic [4:0] PRE_SINGLE   = 5'h18;  // 24 address clocks
  localparam logic [4:0] PRE_DEVID    = 5'h18;  // three dummy bytes
  localparam logic [4:0] PRE_DUAL     = 5'h10;  // 12 address + 4 mode
  localparam logic [4:0] PRE_QUAD     = 5'h0c;  // 4 dummy, 6 addr, 2 mode
  localparam logic [4:0] ALAST_SINGLE = 5'h17;  // clock of address bit 0
  localparam logic [4:0] ALAST_DUAL   = 5'h0b;
  localparam logic [4:0] ALAST_QUAD   = 5'h09;
  localparam logic [4:0] ALAST_NONE   = 5'h1f;  // never reached
  localparam logic [2:0] LANES_1      = 3'h1;
  localparam logic [2:0] LANES_2      = 3'h2;
  localparam logic [2:0] LANES_4      = 3'h4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] SYNC_RST = 6'h01;  // select idles high

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int RESUME_BUSY_NS = 200;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_NS        = 3000;
  localparam int WAKE_ID_NS     = 1800;
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS * 1000 / CLK_PERIOD_PS;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS * 1000 / CLK_PERIOD_PS;
  localparam int WAKE_CYC        = WAKE_NS * 1000 / CLK_PERIOD_PS;
  localparam int WAKE_ID_CYC     = WAKE_ID_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [9:0] SLEEP_LOAD   = 10'(SLEEP_ENTRY_CYC - 1);
  localparam logic [9:0] WAKE_LOAD    = 10'(WAKE_CYC - 1);
  localparam logic [9:0] WAKE_ID_LOAD = 10'(WAKE_ID_CYC - 1);

endpackage : frpic_pkg

// file: verilog/frpic_top.sv
// resume, deep power-down and identification command handling
//
// Functional notes
// - resume taken only when suspended and idle
// - resume clears suspend flag, sets busy quickly
// - resume ignored otherwise, nothing changes
// - power loss clears suspend, later resume ignored
// - power-down only if select rises after bit eight
// - power-down entered one clock after sleep entry delay
// - in power-down only release opcode is recognised
// - power-up always in normal operation
// - release waits wake delay, then commands accepted
// - device id after three dummy bytes, repeating
// - release with id read waits wake id delay
// - release/id opcode ignored while busy
// - address zero: manufacturer id then device id
// - address one: device id first, alternating
// - dual read: address and ids two bits/clock
// - quad read: four dummies, four bits/clock
`timescale 1ns/10ps
module frpic_top
#(
  parameter logic [7:0] MFR_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h17   // arbitrary value
)
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  // serial link pins
  input  wire logic       SEL_BAR,
  input  wire logic       SCLK,
  input  wire logic [3:0] IO_IN,
  output logic      [3:0] IO_OUT,
  output logic      [3:0] IO_OE,
  // suspend and erase/program engine
  input  wire logic       SUSPEND_SET,
  input  wire logic       ENGINE_BUSY,
  output logic            SUSPEND_FLAG,
  output logic            BUSY,
  output logic            RESUME_GO,
  // power state
  output logic            POWER_DOWN
);

  // ****************************************************************
  // types and decode functions
  // ****************************************************************
  typedef enum logic [2:0] {ST_OPC, ST_HOLD, ST_PRE, ST_OUT, ST_IGN}
    frpic_state_t;

  localparam int SLEEP_MAX = frpic_pkg::SLEEP_ENTRY_CYC + 1;
  localparam int RBUSY_MAX = frpic_pkg::RESUME_BUSY_CYC - 1;

  // clocks before the first output bit
  function automatic logic [4:0] frpic_pre(input logic [7:0] op);
    logic [4:0] n;
    n = frpic_pkg::PRE_SINGLE;
    if (op == frpic_pkg::OP_WAKE_ID) n = frpic_pkg::PRE_DEVID;
    if (op == frpic_pkg::OP_MFR_ID2) n = frpic_pkg::PRE_DUAL;
    if (op == frpic_pkg::OP_MFR_ID4) n = frpic_pkg::PRE_QUAD;
    return n;
  endfunction : frpic_pre

  // clock on which address bit 0 arrives
  function automatic logic [4:0] frpic_alast(input logic [7:0] op);
    logic [4:0] n;
    n = frpic_pkg::ALAST_SINGLE;
    if (op == frpic_pkg::OP_WAKE_ID) n = frpic_pkg::ALAST_NONE;
    if (op == frpic_pkg::OP_MFR_ID2) n = frpic_pkg::ALAST_DUAL;
    if (op == frpic_pkg::OP_MFR_ID4) n = frpic_pkg::ALAST_QUAD;
    return n;
  endfunction : frpic_alast

  // data lanes used by an opcode
  function automatic logic [2:0] frpic_lanes(input logic [7:0] op);
    logic [2:0] n;
    n = frpic_pkg::LANES_1;
    if (op == frpic_pkg::OP_MFR_ID2) n = frpic_pkg::LANES_2;
    if (op == frpic_pkg::OP_MFR_ID4) n = frpic_pkg::LANES_4;
    return n;
  endfunction : frpic_lanes

  // output enables for a lane count
  function automatic logic [3:0] frpic_oe(input logic [2:0] ln);
    logic [3:0] m;
    m = 4'h2;
    if (ln == frpic_pkg::LANES_2) m = 4'h3;
    if (ln == frpic_pkg::LANES_4) m = 4'hf;
    return m;
  endfunction : frpic_oe

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [5:0] raw;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] filt_q;
  logic [5:0] filt_d;
  logic       sclk_p_q;
  logic       sel_p_q;

  assign raw = {IO_IN, SCLK, SEL_BAR};

  // a change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_filt
      assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
    end
  endgenerate

  // three stage sampling of the link pins
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      s1_q     <= frpic_pkg::SYNC_RST;
      s2_q     <= frpic_pkg::SYNC_RST;
      s3_q     <= frpic_pkg::SYNC_RST;
      filt_q   <= frpic_pkg::SYNC_RST;
      sclk_p_q <= 1'b0;
      sel_p_q  <= 1'b1;
    end
    else
    begin
      s1_q     <= raw;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      filt_q   <= filt_d;
      sclk_p_q <= filt_q[1];
      sel_p_q  <= filt_q[0];
    end
  end

  // ****************************************************************
  // edge and frame decode
  // ****************************************************************
  logic       sel_act;
  logic       sel_rise;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] io_f;

  assign sel_act   = ~filt_q[0];
  assign sel_rise  = filt_q[0] & ~sel_p_q;
  assign sclk_rise = sel_act & filt_q[1] & ~sclk_p_q;
  assign sclk_fall = sel_act & ~filt_q[1] & sclk_p_q;
  assign io_f      = filt_q[5:2];

  // ****************************************************************
  // command state
  // ****************************************************************
  frpic_state_t st_q;
  frpic_state_t st_d;
  frpic_state_t nxt_cmd;
  logic [4:0]   cnt_q;
  logic [4:0]   cnt_d;
  logic [7:0]   op_q;
  logic [7:0]   op_n;
  logic [4:0]   pre_q;
  logic [4:0]   alast_q;
  logic [2:0]   lanes_q;
  logic         a0_q;
  logic         op_done;
  logic         pre_done;
  logic         known_op;
  logic         cmd_ok;
  logic         susp_q;
  logic         busy_q;
  logic         hold_q;
  logic         pd_q;
  logic         sleep_pend_q;
  logic         wake_pend_q;
  logic [9:0]   tmr_q;

  assign op_done  = sclk_rise & (st_q == ST_OPC) &
                    (cnt_q == frpic_pkg::OPC_LAST);
  assign op_n     = {op_q[6:0], io_f[0]};
  assign pre_done = (st_q == ST_PRE) & (cnt_q == pre_q - 5'h01);
  assign known_op = (op_n == frpic_pkg::OP_RESUME) |
                    (op_n == frpic_pkg::OP_SLEEP) |
                    (op_n == frpic_pkg::OP_WAKE_ID) |
                    (op_n == frpic_pkg::OP_MFR_ID1) |
                    (op_n == frpic_pkg::OP_MFR_ID2) |
                    (op_n == frpic_pkg::OP_MFR_ID4);

  // gate opcodes on power state, pending timers and busy
  assign cmd_ok = ~sleep_pend_q & ~wake_pend_q &
                  (pd_q ? (op_n == frpic_pkg::OP_WAKE_ID) : known_op) &
                  ~((op_n == frpic_pkg::OP_WAKE_ID) & busy_q);

  assign nxt_cmd = !cmd_ok ? ST_IGN :
                   ((op_n == frpic_pkg::OP_SLEEP) |
                    (op_n == frpic_pkg::OP_RESUME)) ? ST_HOLD : ST_PRE;

  // next command state
  always_comb
  begin
    st_d = st_q;
    if (!sel_act)
      st_d = ST_OPC;
    else if (sclk_rise)
    begin
      unique case (st_q)
        ST_OPC:  if (cnt_q == frpic_pkg::OPC_LAST) st_d = nxt_cmd;
        ST_HOLD: st_d = ST_IGN;  // clocks past bit eight void it
        ST_PRE:  if (pre_done) st_d = ST_OUT;
        ST_OUT:  st_d = ST_OUT;
        ST_IGN:  st_d = ST_IGN;
        default: st_d = ST_IGN;
      endcase
    end
  end

  // clock counter runs only through opcode and preamble
  assign cnt_d = !sel_act ? 5'h00 :
                 !sclk_rise ? cnt_q :
                 op_done ? 5'h00 :
                 ((st_q == ST_OPC) | (st_q == ST_PRE)) ? cnt_q + 5'h01 :
                 cnt_q;

  // frame registers
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      st_q    <= ST_OPC;
      cnt_q   <= 5'h00;
      op_q    <= 8'h00;
      pre_q   <= frpic_pkg::PRE_SINGLE;
      alast_q <= frpic_pkg::ALAST_NONE;
      lanes_q <= frpic_pkg::LANES_1;
      a0_q    <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (sclk_rise & (st_q == ST_OPC))
        op_q <= op_n;
      if (op_done)
      begin
        pre_q   <= frpic_pre(op_n);
        alast_q <= frpic_alast(op_n);
        lanes_q <= frpic_lanes(op_n);
        a0_q    <= 1'b0;
      end
      if (sclk_rise & (st_q == ST_PRE) & (cnt_q == alast_q))
        a0_q <= io_f[0];
    end
  end

  // ****************************************************************
  // actions taken when select rises
  // ****************************************************************
  logic exec_sleep;
  logic exec_resume;
  logic exec_wake;

  assign exec_sleep  = sel_rise & (st_q == ST_HOLD) &
                       (op_q == frpic_pkg::OP_SLEEP);
  assign exec_resume = sel_rise & (st_q == ST_HOLD) &
                       (op_q == frpic_pkg::OP_RESUME) & susp_q &
                       ~busy_q;
  assign exec_wake   = sel_rise & pd_q & (op_q == frpic_pkg::OP_WAKE_ID) &
                       ((st_q == ST_PRE) | (st_q == ST_OUT));

  // suspend flag, busy and resume strobe; set wins over clear
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      susp_q <= 1'b0;  // lost power drops suspension
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      RESUME_GO <= 1'b0;
    end
    else
    begin
      susp_q <= SUSPEND_SET | (susp_q & ~exec_resume);
      busy_q <= ENGINE_BUSY | exec_resume | hold_q;
      hold_q <= exec_resume | (hold_q & ~ENGINE_BUSY);
      RESUME_GO <= exec_resume;
    end
  end

  // power-down entry and release timers
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      pd_q         <= 1'b0;
      sleep_pend_q <= 1'b0;
      wake_pend_q  <= 1'b0;
      tmr_q        <= 10'h000;
    end
    else if (exec_sleep)
    begin
      sleep_pend_q <= 1'b1;
      tmr_q        <= frpic_pkg::SLEEP_LOAD;
    end
    else if (exec_wake)
    begin
      wake_pend_q <= 1'b1;
      tmr_q <= (st_q == ST_OUT) ? frpic_pkg::WAKE_ID_LOAD :
                                  frpic_pkg::WAKE_LOAD;
    end
    else if (sleep_pend_q | wake_pend_q)
    begin
      tmr_q <= tmr_q - 10'h001;
      if (tmr_q == 10'h000)
      begin
        pd_q         <= sleep_pend_q;
        sleep_pend_q <= 1'b0;
        wake_pend_q  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // identification output
  // ****************************************************************
  logic [15:0] word_w;
  logic [15:0] word_sh;
  logic [3:0]  nib_w;
  logic [3:0]  ptr_q;
  logic [3:0]  out_q;
  logic [3:0]  oe_q;

  // device id alone, or the pair in address order
  assign word_w  = (op_q == frpic_pkg::OP_WAKE_ID) ? {DEV_ID, DEV_ID} :
                   a0_q ? {DEV_ID, MFR_ID} : {MFR_ID, DEV_ID};
  assign word_sh = word_w << ptr_q;
  assign nib_w   = (lanes_q == frpic_pkg::LANES_4) ? word_sh[15:12] :
                   (lanes_q == frpic_pkg::LANES_2) ? {2'b00, word_sh[15:14]} :
                   {2'b00, word_sh[15], 1'b0};

  // msb first on falling edges, released outside the data phase
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      ptr_q <= 4'h0;
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end
    else if (st_d != ST_OUT)
    begin
      ptr_q <= 4'h0;
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end
    else if (sclk_fall)
    begin
      out_q <= nib_w;
      oe_q  <= frpic_oe(lanes_q);
      ptr_q <= ptr_q + {1'b0, lanes_q};      // wraps to alternate ids
    end
  end

  assign IO_OUT       = out_q;
  assign IO_OE        = oe_q;
  assign SUSPEND_FLAG = susp_q;
  assign BUSY         = busy_q;
  assign POWER_DOWN   = pd_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_sleep_cmd;
    exec_sleep;
  endsequence
  sequence s_sleep_done;
    ##[1:SLEEP_MAX] pd_q;
  endsequence
  sequence s_resume_cmd;
    exec_resume && !SUSPEND_SET;
  endsequence
  // flag drops on the next edge, busy must show within the window
  sequence s_resume_done;
    !susp_q ##[0:RBUSY_MAX] busy_q;
  endsequence

  a_resume_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
    RESUME_GO |-> $past(susp_q) && !$past(busy_q))
    else $error("resume accepted without suspension or while busy");
  a_resume_effect: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_resume_cmd |=> s_resume_done)
    else $error("resume did not clear suspend and set busy");
  a_resume_ignore: assert property (@(posedge MCLK) disable iff (!RSTN)
    sel_rise && st_q == ST_HOLD && op_q == frpic_pkg::OP_RESUME &&
    (!susp_q || busy_q) |=> !RESUME_GO && $stable(susp_q))
    else $error("ignored resume changed state");
  a_sleep_entry: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_sleep_cmd |-> s_sleep_done)
    else $error("power-down not entered in time");
  a_sleep_frame: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(sleep_pend_q) |-> $past(st_q) == ST_HOLD && $past(cnt_q) == 5'h00)
    else $error("power-down taken without exact opcode frame");
  a_pd_filter: assert property (@(posedge MCLK) disable iff (!RSTN)
    pd_q && op_done && op_n != frpic_pkg::OP_WAKE_ID |=> st_q == ST_IGN)
    else $error("opcode recognised during power-down");
  a_start_normal: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(RSTN) |-> !POWER_DOWN)
    else $error("device came out of reset powered down");
  a_busy_id: assert property (@(posedge MCLK) disable iff (!RSTN)
    op_done && op_n == frpic_pkg::OP_WAKE_ID && busy_q |=> st_q == ST_IGN)
    else $error("release/id opcode taken while busy");
  a_hiz_idle: assert property (@(posedge MCLK) disable iff (!RSTN)
    st_q != ST_OUT |-> IO_OE == 4'h0)
    else $error("outputs driven outside data phase");
  a_first_bits: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(|oe_q) |-> IO_OE == frpic_oe(lanes_q) &&
    IO_OUT == ((lanes_q == frpic_pkg::LANES_4) ? word_w[15:12] :
               (lanes_q == frpic_pkg::LANES_2) ? {2'b00, word_w[15:14]} :
               {2'b00, word_w[15], 1'b0}))
    else $error("first id bits wrong");

endmodule : frpic_top

// file: testbench/frpic_host.sv
// host side serial flash controller model driving the link pins
`timescale 1ns/10ps
module frpic_host
(
  // link pins
  output logic            SEL_BAR,
  output logic            SCLK,
  output logic      [3:0] IO_IN,
  input  wire logic [3:0] IO_OUT,
  input  wire logic [3:0] IO_OE
);
  // ****************************************************************
  // lane resolution
  // ****************************************************************
  logic [3:0] hd_q;  // host drive, toggled while released
  // device wins where it enables, host elsewhere
  assign IO_IN = (IO_OE & IO_OUT) | (~IO_OE & hd_q);
  initial
  begin
    SEL_BAR = 1'b1;
    SCLK = 1'b0;
    hd_q = 4'h0;
  end
  // ****************************************************************
  // one select-low frame, mode 0, 48 ns link clock
  // ****************************************************************
  task automatic frame(input logic [7:0] op, input int pre, al, ln, nout,
                       input logic a0, output logic [63:0] got,
                       output logic [3:0] oe_p, oe_d);
    int i;
    int j;
    logic [3:0] m;
    got = '0;
    oe_p = '0;
    oe_d = '0;
    m = 4'($urandom);  // free low nibble of the mode byte
    SEL_BAR <= 1'b0;
    #24;
    for (i = 0; i < 8 + pre; i++)
    begin
      j = i - 8;
      if (i < 8)
        hd_q <= {3'h0, op[7 - i]};
      else if (j == al)
        hd_q <= {3'h0, a0};
      else if (j > al && j <= al + (pre - 1 - al) / 2)
        hd_q <= 4'hf;
      else
        hd_q <= (j > al) ? m : 4'h0;
      #24 SCLK <= 1'b1;
      oe_p = oe_p | IO_OE;
      #24 SCLK <= 1'b0;
    end
    for (i = 0; i < nout; i++)
    begin
      hd_q <= ~hd_q;  // released lanes never hold a value
      #24 SCLK <= 1'b1;
      #23;
      oe_d = oe_d | IO_OE;
      if (ln == 4)
        got = {got[59:0], IO_OUT};
      else if (ln == 2)
        got = {got[61:0], IO_OUT[1:0]};
      else
        got = {got[62:0], IO_OUT[1]};
      #1 SCLK <= 1'b0;
    end
    #24 SEL_BAR <= 1'b1;
    #24;
  endtask : frame
endmodule : frpic_host

// file: testbench/frpic_top_bench.sv
// self-checking bench for the resume, power-down and id block
`timescale 1ns/10ps
module frpic_top_bench;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [7:0] MFR = 8'h3c;  // arbitrary value
  localparam logic [7:0] DEV = 8'h71;  // arbitrary value
  localparam int SUS_LAT = 100;        // host spacing after resume
  localparam int SLP = frpic_pkg::SLEEP_ENTRY_CYC + 20;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        susp_set = 1'b0;
  logic        eng_busy = 1'b0;
  logic        sel_bar;
  logic        sclk;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        sus_flag;
  logic        busy;
  logic        res_go;
  logic        pwr_dn;
  logic [63:0] got;
  logic [3:0]  oe_p;
  logic [3:0]  oe_d;
  logic [7:0]  ops [6] = '{8'h90, 8'h90, 8'h92, 8'h92, 8'h94, 8'h94};
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n_go = 0;
  int          k;
  // clock and resume pulse counter
  always #2.5 mclk = ~mclk;
  always @(posedge mclk)
    if (res_go === 1'b1)
      n_go <= n_go + 1;
  frpic_top #(.MFR_ID(MFR), .DEV_ID(DEV)) DUT
  (
    .MCLK(mclk), .RSTN(rstn), .SEL_BAR(sel_bar), .SCLK(sclk),
    .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe),
    .SUSPEND_SET(susp_set), .ENGINE_BUSY(eng_busy),
    .SUSPEND_FLAG(sus_flag), .BUSY(busy), .RESUME_GO(res_go),
    .POWER_DOWN(pwr_dn)
  );
  frpic_host host
  (
    .SEL_BAR(sel_bar), .SCLK(sclk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe)
  );
  // ****************************************************************
  // compare tasks and reference model
  // ****************************************************************
  task automatic chk_bit(input string nm, input logic e, s);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_bit
  task automatic chk_val(input string nm, input logic [63:0] e, s);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_val
  // alternating id stream, or device id only for the release opcode
  function automatic logic [63:0] exp_ids(input logic a0, dv);
    logic [7:0] q [$];
    int i;
    exp_ids = '0;
    for (i = 0; i < 8; i++)
      q.push_back((dv || (i[0] ^ a0)) ? DEV : MFR);
    foreach (q[j])
      exp_ids = {exp_ids[55:0], q[j]};
  endfunction : exp_ids
  // id read frame; ok low means the device must stay silent
  task automatic id_read(input logic [7:0] op, input logic a0, ok);
    int ln;
    int pre;
    int al;
    logic [3:0] oe_x;
    ln = (op == 8'h94) ? 4 : (op == 8'h92) ? 2 : 1;
    pre = (ln == 4) ? 12 : (ln == 2) ? 16 : 24;
    al = (op == 8'hab) ? 31 : (ln == 4) ? 9 : (ln == 2) ? 11 : 23;
    oe_x = ok ? ((ln == 4) ? 4'hf : (ln == 2) ? 4'h3 : 4'h2) : 4'h0;
    host.frame(op, pre, al, ln, 64 / ln, a0, got, oe_p, oe_d);
    chk_val("oe_preamble", 64'h0, 64'(oe_p));
    chk_val("oe_data", 64'(oe_x), 64'(oe_d));
    if (ok)
      chk_val("ids", exp_ids(a0, op == 8'hab), got);
  endtask : id_read
  task automatic cmd(input logic [7:0] op, input int extra);
    host.frame(op, extra, 31, 1, 0, 1'b0, got, oe_p, oe_d);
  endtask : cmd
  task automatic wait_pd(input logic v, input int n);
    int i;
    for (i = 0; i < n && pwr_dn !== v; i++)
      @(posedge mclk);
    chk_bit("power_down", v, pwr_dn);
  endtask : wait_pd
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    #400000;
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    end_sim;
  end
  initial
  begin
    void'($urandom(54026));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_bit("power_down", 1'b0, pwr_dn);
    for (k = 0; k < 6; k++)
      id_read(ops[k], 1'(k), 1'b1);
    id_read(8'hab, 1'b0, 1'b1);
    $display("test id reads done");
    cmd(8'h7a, 0);
    repeat (40) @(posedge mclk);
    chk_val("resume_go", 64'h0, 64'(n_go));
    susp_set <= 1'b1;
    eng_busy <= 1'b1;
    @(posedge mclk);
    susp_set <= 1'b0;
    cmd(8'h7a, 0);
    repeat (40) @(posedge mclk);
    chk_bit("suspend", 1'b1, sus_flag);
    chk_val("resume_go", 64'h0, 64'(n_go));
    id_read(8'hab, 1'b0, 1'b0);
    eng_busy <= 1'b0;
    repeat (4) @(posedge mclk);
    cmd(8'h7a, 0);
    repeat (35) @(posedge mclk);
    chk_bit("suspend", 1'b0, sus_flag);
    chk_bit("busy", 1'b1, busy);
    chk_val("resume_go", 64'h1, 64'(n_go));
    eng_busy <= 1'b1;
    repeat (SUS_LAT) @(posedge mclk);
    susp_set <= 1'b1;
    eng_busy <= 1'b0;
    @(posedge mclk);
    susp_set <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    cmd(8'h7a, 0);
    repeat (40) @(posedge mclk);
    chk_val("resume_go", 64'h1, 64'(n_go));
    chk_bit("suspend", 1'b0, sus_flag);
    $display("test resume done");
    cmd(8'hb9, 1);
    repeat (SLP) @(posedge mclk);
    chk_bit("power_down", 1'b0, pwr_dn);
    cmd(8'hb9, 0);
    wait_pd(1'b1, SLP);
    id_read(8'h90, 1'b0, 1'b0);
    cmd(8'hab, 0);
    wait_pd(1'b0, frpic_pkg::WAKE_CYC + 20);
    id_read(8'h90, 1'b1, 1'b1);
    cmd(8'hb9, 0);
    wait_pd(1'b1, SLP);
    id_read(8'hab, 1'b0, 1'b1);
    wait_pd(1'b0, frpic_pkg::WAKE_ID_CYC + 20);
    id_read(8'h92, 1'b0, 1'b1);
    $display("test power-down done");
    end_sim;
  end
endmodule : frpic_top_bench
